// ### hw/rcbm_top.sv
// Reset extension, clock boot-mode decode and pad defaults
// Functional notes
// R1 - External reset asserts core and peripheral reset at once, unclocked.
// R2 - Reset indication stays low 512 clocks after reset release.
// R3 - Straps 00: PLL off, external osc if osc pin 0, on-chip if 1.
// R4 - Straps 01: PLL off, crystal, osc pin ignored.
// R5 - Straps 10: PLL on, external osc if osc pin 0, on-chip if 1.
// R6 - Straps 11: PLL on, crystal, osc pin ignored.
// R7 - Osc output pin drives crystal except where sampled as a mode input.
// R8 - Osc input pin is used except when the on-chip oscillator is chosen.
// R9 - Boot pin high and test pin low at release enters flash programming.
// R10 - Board holds the test pin at ground in normal use.
// R11 - System clock output copies the internal clock.
// R12 - Pads default to 2mA drive and fast slew out of reset.
// R13 - A pad in general-purpose mode has its pull-up enabled.
// R14 - Straps are sampled once at reset release and held until next reset.
// R15 - Reset indication is low throughout the external reset too.
`timescale 1ns/1ps
`default_nettype none
module rcbm_top (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic external_reset_input_n,
	input wire logic [1:0] clock_mode_straps,
	input wire logic oscillator_output_pin_in,
	input wire logic boot_configuration_pin,
	input wire logic factory_test_pin,
	input wire logic [rcbm_pkg::PAD_COUNT-1:0] pad_gpio_select,
	output logic oscillator_output_pin_oe,
	output logic core_reset,
	output logic reset_indication_output_n,
	output logic system_clock_output,
	output var rcbm_pkg::rcbm_boot_s boot_cfg_r,
	output logic [rcbm_pkg::PAD_COUNT-1:0] pad_drive_strength_control_r,
	output logic [rcbm_pkg::PAD_COUNT-1:0] pad_slew_rate_control_r,
	output logic [rcbm_pkg::PAD_COUNT-1:0] pad_pullup_enable_r
);
	logic any_rst;
	logic [4:0] pins_sync;
	logic [1:0] straps_s;
	logic osc_s;
	logic boot_s;
	logic test_s;
	rcbm_pkg::rcbm_state_e state_r;
	rcbm_pkg::rcbm_state_e state_nxt;
	logic [rcbm_pkg::CNT_W-1:0] cnt_r;
	logic [rcbm_pkg::CNT_W-1:0] cnt_nxt;
	rcbm_pkg::rcbm_boot_s boot_nxt;
	logic reset_indication_output_nxt;
	logic core_rst_nxt;
	logic [rcbm_pkg::PAD_COUNT-1:0] pull_nxt;

	// Pin reset acts without the clock [R1]
	assign any_rst = sys_rst | ~external_reset_input_n;

	rcbm_sync #(
		.W(5)
	) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.din({clock_mode_straps, oscillator_output_pin_in,
			boot_configuration_pin, factory_test_pin}),
		.dout(pins_sync)
	);
	assign straps_s = pins_sync[4:3];
	assign osc_s = pins_sync[2];
	assign boot_s = pins_sync[1];
	assign test_s = pins_sync[0];

	function automatic rcbm_pkg::rcbm_boot_s decode_mode(
		input logic [1:0] straps,
		input logic osc,
		input logic boot,
		input logic test
	);
		rcbm_pkg::rcbm_boot_s d;
		d.pll_enable = straps[1]; // [R3] [R4] [R5] [R6]
		unique case (straps)
			rcbm_pkg::MODE_PLLOFF_OSC, rcbm_pkg::MODE_PLLON_OSC: begin
				d.clock_source = osc ? rcbm_pkg::RCBM_SRC_ONCHIP :
					rcbm_pkg::RCBM_SRC_EXT_OSC; // [R3] [R5]
				d.osc_output_drive = 1'b0; // [R7]
			end
			rcbm_pkg::MODE_PLLOFF_OSCILLATOR_OUTPUT_PIN, rcbm_pkg::MODE_PLLON_OSCILLATOR_OUTPUT_PIN: begin
				d.clock_source = rcbm_pkg::RCBM_SRC_CRYSTAL; // [R4] [R6]
				d.osc_output_drive = 1'b1; // [R7]
			end
		endcase
		d.osc_input_used =
			(d.clock_source != rcbm_pkg::RCBM_SRC_ONCHIP); // [R8]
		d.flash_prog_mode = boot & ~test; // [R9] [R10]
		return d;
	endfunction : decode_mode

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		boot_nxt = boot_cfg_r;
		reset_indication_output_nxt = 1'b0;
		core_rst_nxt = 1'b0;
		unique case (state_r)
			rcbm_pkg::RCBM_HOLD: begin
				// First clock after release: latch straps once [R14]
				boot_nxt = decode_mode(straps_s, osc_s, boot_s, test_s);
				cnt_nxt = '0;
				state_nxt = rcbm_pkg::RCBM_EXTEND;
			end
			rcbm_pkg::RCBM_EXTEND: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == rcbm_pkg::CNT_LAST) begin
					state_nxt = rcbm_pkg::RCBM_RUN; // [R2]
					reset_indication_output_nxt = 1'b1;
				end
			end
			rcbm_pkg::RCBM_RUN: begin
				reset_indication_output_nxt = 1'b1;
			end
			default: begin
				state_nxt = rcbm_pkg::RCBM_HOLD;
			end
		endcase
	end

	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			state_r <= rcbm_pkg::RCBM_HOLD;
			cnt_r <= '0;
			reset_indication_output_n <= 1'b0; // [R15]
			core_reset <= 1'b1; // [R1]
			boot_cfg_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			reset_indication_output_n <= reset_indication_output_nxt; // [R2]
			core_reset <= core_rst_nxt;
			boot_cfg_r <= boot_nxt;
		end
	end

	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			oscillator_output_pin_oe <= 1'b0;
		end else begin
			oscillator_output_pin_oe <= boot_nxt.osc_output_drive; // [R7]
		end
	end

	always_comb begin
		pull_nxt = pad_gpio_select; // [R13]
	end

	// Drive and slew hold defaults; no register path alters them here
	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			pad_drive_strength_control_r <= {rcbm_pkg::PAD_COUNT{
				rcbm_pkg::PAD_DRIVE_2MA}}; // [R12]
			pad_slew_rate_control_r <= {rcbm_pkg::PAD_COUNT{
				rcbm_pkg::PAD_SLEW_FAST}}; // [R12]
			pad_pullup_enable_r <= '0;
		end else begin
			pad_drive_strength_control_r <= pad_drive_strength_control_r;
			pad_slew_rate_control_r <= pad_slew_rate_control_r;
			pad_pullup_enable_r <= pull_nxt; // [R13]
		end
	end

	// Only unregistered output: a flop cannot copy its own clock
	always_comb begin
		system_clock_output = clock; // [R11]
	end
endmodule : rcbm_top
`default_nettype wire

// ### hw/rcbm_pkg.sv
// Package: constants and carriers for reset and clock boot-mode logic
package rcbm_pkg;
	localparam int RST_EXT_CYCLES = 512;
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] CNT_LAST = 10'h1FF;
	localparam int PAD_COUNT = 28;
	localparam logic [1:0] MODE_PLLOFF_OSC = 2'h0;
	localparam logic [1:0] MODE_PLLOFF_OSCILLATOR_OUTPUT_PIN = 2'h1;
	localparam logic [1:0] MODE_PLLON_OSC = 2'h2;
	localparam logic [1:0] MODE_PLLON_OSCILLATOR_OUTPUT_PIN = 2'h3;
	// Drive setting 0 = 2mA, slew setting 1 = fast
	localparam logic PAD_DRIVE_2MA = 1'b0;
	localparam logic PAD_SLEW_FAST = 1'b1;

	typedef enum logic [1:0] {
		RCBM_HOLD = 2'b00,
		RCBM_EXTEND = 2'b01,
		RCBM_RUN = 2'b11
	} rcbm_state_e;

	typedef enum logic [1:0] {
		RCBM_SRC_EXT_OSC = 2'h0,
		RCBM_SRC_ONCHIP = 2'h1,
		RCBM_SRC_CRYSTAL = 2'h2
	} rcbm_src_e;

	typedef struct packed {
		logic pll_enable;
		rcbm_src_e clock_source;
		logic osc_input_used;
		logic osc_output_drive;
		logic flash_prog_mode;
	} rcbm_boot_s;
endpackage : rcbm_pkg

// ### hw/rcbm_sync.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module rcbm_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_nxt;

	always_comb begin
		meta_nxt = din;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= meta_nxt;
			dout <= sync_nxt;
		end
	end
endmodule : rcbm_sync
`default_nettype wire

// ### test/rcbm_top_sva.sv
// Checker for reset extension, boot-mode decode and pad defaults
`timescale 1ns/1ps
`default_nettype none
module rcbm_top_sva (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic external_reset_input_n,
	input wire logic [1:0] clock_mode_straps,
	input wire logic oscillator_output_pin_in,
	input wire logic boot_configuration_pin,
	input wire logic factory_test_pin,
	input wire logic [rcbm_pkg::PAD_COUNT-1:0] pad_gpio_select,
	input wire logic oscillator_output_pin_oe,
	input wire logic core_reset,
	input wire logic reset_indication_output_n,
	input wire rcbm_pkg::rcbm_boot_s boot_cfg_r,
	input wire logic [rcbm_pkg::PAD_COUNT-1:0] pad_drive_strength_control_r,
	input wire logic [rcbm_pkg::PAD_COUNT-1:0] pad_slew_rate_control_r,
	input wire logic [rcbm_pkg::PAD_COUNT-1:0] pad_pullup_enable_r
);
	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	wire logic xr = ~external_reset_input_n;
	wire logic [1:0] md = clock_mode_straps;
	wire logic c1 = (cnt_r == 10'h001);
	// Saturates so the count never wraps back into the window
	always_comb cnt_nxt = (cnt_r == 10'h3ff) ? cnt_r : cnt_r + 10'h001;
	always_ff @(posedge clock or posedge sys_rst or posedge xr) begin
		if (sys_rst | xr) cnt_r <= '0;
		else cnt_r <= cnt_nxt;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_reset_core: assert property (xr |-> core_reset)
		else $error("core reset not held");
	a_reset_out: assert property (xr |-> !reset_indication_output_n)
		else $error("reset out high during reset");
	a_out_timing: assert property (!xr |->
		reset_indication_output_n == (cnt_r >= 10'h201))
		else $error("reset out timing wrong");
	a_mode_pll: assert property (c1 |-> boot_cfg_r.pll_enable == md[1]
		&& oscillator_output_pin_oe == md[0])
		else $error("pll or osc drive wrong");
	a_mode_src: assert property (c1 |-> boot_cfg_r.clock_source ==
		(md[0] ? 2'h2 : {1'b0, oscillator_output_pin_in}))
		else $error("clock source wrong");
	a_osc_in: assert property (cnt_r != 0 |->
		boot_cfg_r.osc_input_used == (boot_cfg_r.clock_source != 2'h1))
		else $error("osc input use wrong");
	a_flash_entry: assert property (c1 |-> boot_cfg_r.flash_prog_mode ==
		(boot_configuration_pin & ~factory_test_pin))
		else $error("flash mode wrong");
	a_cfg_hold: assert property (cnt_r > 10'h001 |->
		$stable(boot_cfg_r) && $stable(oscillator_output_pin_oe))
		else $error("boot config changed");
	a_pad_dflt: assert property (pad_drive_strength_control_r == '0
		&& pad_slew_rate_control_r == '1) else $error("pad defaults wrong");
	a_pullup: assert property (cnt_r != 0 |->
		pad_pullup_enable_r == $past(pad_gpio_select))
		else $error("pullup wrong");
	cover property (c1 && boot_cfg_r.pll_enable);
	cover property (c1 && boot_cfg_r.flash_prog_mode);
	cover property ($rose(reset_indication_output_n));
endmodule : rcbm_top_sva
bind rcbm_top rcbm_top_sva u_sva (.*);
`default_nettype wire

// ### test/rcbm_board.sv
// Board model: strap drivers, test pin grounded
`timescale 1ns/1ps
`default_nettype none
module rcbm_board (
	input wire logic clock,
	input wire logic [3:0] cfg,
	output logic [1:0] straps,
	output logic osc,
	output logic boot,
	output logic test
);
	logic [3:0] q_r = 4'h0;
	always_ff @(posedge clock) q_r <= cfg;
	assign {straps, osc, boot} = q_r;
	assign test = 1'b0;
endmodule : rcbm_board
`default_nettype wire

// ### test/rcbm_top_tb_top.sv
// Testbench: every strap mode through reset and release
`timescale 1ns/1ps
`default_nettype none
module rcbm_top_tb_top;
	logic clock = 0, sys_rst = 1, rst_n = 1, osc, boot, test, oe, core_rst;
	logic rst_out, clk_out;
	logic [1:0] straps;
	logic [3:0] cfg = 4'h0;
	logic [27:0] sel = 28'h000_0000, drv, slw, pu;
	rcbm_pkg::rcbm_boot_s boot_cfg_r;
	int bad_count = 0, checked = 0;
	always #5 clock = ~clock;
	rcbm_board u_board (.clock(clock), .cfg(cfg), .straps(straps),
		.osc(osc), .boot(boot), .test(test));
	rcbm_top DUT (.clock(clock), .sys_rst(sys_rst),
		.external_reset_input_n(rst_n), .clock_mode_straps(straps),
		.oscillator_output_pin_in(osc), .boot_configuration_pin(boot),
		.factory_test_pin(test), .pad_gpio_select(sel),
		.oscillator_output_pin_oe(oe), .core_reset(core_rst),
		.reset_indication_output_n(rst_out), .system_clock_output(clk_out),
		.boot_cfg_r(boot_cfg_r), .pad_drive_strength_control_r(drv),
		.pad_slew_rate_control_r(slw), .pad_pullup_enable_r(pu));
	task automatic chk(input string n, input logic [27:0] e, s);
		checked++;
		if (s !== e) begin
			$display("[FAIL] %s exp %h got %h", n, e, s);
			bad_count++;
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	// cfg = {straps, osc pin, boot pin}; test pin is grounded
	function automatic logic [5:0] expv(input logic [3:0] c);
		expv = {c[3], c[2] ? 2'h2 : {1'b0, c[1]}, ~(~c[2] & c[1]), c[2], c[0]};
	endfunction : expv
	initial begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		for (int m = 0; m < 16; m++) begin
			@(posedge clock);
			cfg <= m[3:0];
			rst_n <= 1'b0;
			sel <= {7{m[3:0]}};
			#1 chk("core_reset at once", 1, core_rst);
			chk("rst_out at once", 0, rst_out);
			// Straps need time through the board and synchroniser
			repeat (4) @(posedge clock);
			#1 chk("core_reset", 1, core_rst);
			chk("rst_out low", 0, rst_out);
			@(posedge clock);
			rst_n <= 1'b1;
			@(posedge clock);
			#1 chk("boot_cfg", expv(m[3:0]), boot_cfg_r);
			chk("osc_oe", m[2], oe);
			chk("drive", 0, drv);
			chk("slew", 28'hfff_ffff, slw);
			@(posedge clock);
			cfg <= ~m[3:0];
			sel <= ~sel;
			repeat (510) @(posedge clock);
			#1 chk("rst_out 512", 0, rst_out);
			chk("pullup", sel, pu);
			@(posedge clock);
			#1 chk("rst_out 513", 1, rst_out);
			chk("boot_cfg held", expv(m[3:0]), boot_cfg_r);
			chk("clk_out", clock, clk_out);
		end
		summarize();
	end
	initial begin
		#150000;
		bad_count++;
		summarize();
	end
endmodule : rcbm_top_tb_top
`default_nettype wire
